// >>> flash_poll_pkg.sv
`default_nettype none
package flash_poll_pkg;
  localparam int          CLK_NS        = 10;
  localparam int          ACCESS_NS     = 120;
  localparam int          RECOVER_NS    = 30;
  localparam int          ACCESS_CYC    = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int          RECOVER_CYC   = (RECOVER_NS + CLK_NS - 1) / CLK_NS;
  localparam int          SYNC_CYC      = 4;
  localparam int          FLASH_ADDR_W  = 22;
  localparam int          REG_ADDR_W    = 5;
  localparam logic [4:0]  OFF_CTRL      = 5'h00;
  localparam logic [4:0]  OFF_ADDR      = 5'h04;
  localparam logic [4:0]  OFF_EXPECT    = 5'h08;
  localparam logic [4:0]  OFF_STATUS    = 5'h0c;
  localparam int          CTRL_START    = 0;
  localparam int          CTRL_TOGGLE   = 1;
  localparam int          CTRL_ERASE    = 2;
  localparam int          BIT_POLL      = 7;
  localparam int          BIT_TOG1      = 6;
  localparam int          BIT_LIMIT     = 5;
  localparam int          BIT_WINDOW    = 3;
  localparam int          BIT_TOG2      = 2;
  localparam logic [2:0]  CTRL_RESET    = 3'h0;
  localparam logic [7:0]  EXPECT_RESET  = 8'h00;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage
`default_nettype wire

// >>> flash_read_cycle.sv
`timescale 1ns/100ps
`default_nettype none
module flash_read_cycle
  import flash_poll_pkg::*;
#(
  parameter int AW      = FLASH_ADDR_W,
  parameter int LOW_CYC = ACCESS_CYC + SYNC_CYC,
  parameter int HI_CYC  = RECOVER_CYC
) (
  input  wire logic          clock,
  input  wire logic          rstn,
  input  wire logic          start,
  input  wire logic [AW-1:0] addrIn,
  input  wire logic [7:0]    dataPin,
  input  wire logic          readyBusyNPin,
  output logic               chipSelectN,
  output logic               outputEnableN,
  output logic [AW-1:0]      flashAddr,
  output logic [7:0]         byteOut,
  output logic               readDone,
  output logic               readyLevel
);
  typedef enum logic [1:0] {R_IDLE = 2'b00, R_LOW = 2'b01, R_HIGH = 2'b10} rd_state_t;
  typedef struct packed {
    rd_state_t     st;
    logic [7:0]    cnt;
    logic          csN;
    logic          oeN;
    logic [AW-1:0] addr;
    logic [7:0]    data;
    logic          done;
    logic [8:0]    s1;
    logic [8:0]    s2;
    logic [8:0]    s3;
    logic [8:0]    stable;
  } rd_t;
  rd_t q;
  rd_t d;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    d = q;
    d.done = 1'b0;
    // s1 feeds s2 only; a change counts once s2 and s3 agree
    d.s1 = {readyBusyNPin, dataPin};
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < 9; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        d.stable[i] = q.s3[i];
      end
    end
    unique case (q.st)
      R_IDLE: begin
        if (start) begin
          d.addr = addrIn;
          d.csN  = 1'b0;
          d.oeN  = 1'b0;
          d.cnt  = 8'(LOW_CYC - 1);
          d.st   = R_LOW;
        end
      end
      R_LOW: begin
        if (q.cnt == 8'h00) begin
          d.data = q.stable[7:0];
          // strobes rise here, completing the cycle that steps the toggle bits
          d.csN  = 1'b1; // RULE23
          d.oeN  = 1'b1;
          d.cnt  = 8'(HI_CYC - 1);
          d.st   = R_HIGH;
        end else begin
          d.cnt = q.cnt - 8'h01;
        end
      end
      R_HIGH: begin
        if (q.cnt == 8'h00) begin
          d.done = 1'b1;
          d.st   = R_IDLE;
        end else begin
          d.cnt = q.cnt - 8'h01;
        end
      end
      default: d.st = R_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      q <= '{st: R_IDLE, cnt: 8'h00, csN: 1'b1, oeN: 1'b1, addr: '0, data: 8'h00,
             done: 1'b0, s1: 9'h1ff, s2: 9'h1ff, s3: 9'h1ff, stable: 9'h1ff};
    end else begin
      q <= d;
    end
  end

  assign chipSelectN   = q.csN;
  assign outputEnableN = q.oeN;
  assign flashAddr     = q.addr;
  assign byteOut       = q.data;
  assign readDone      = q.done;
  assign readyLevel    = q.stable[8];

  ////////////////////////////////////////////////////////////////////////////
  AST_STROBE_LOW: assert property (@(posedge clock) disable iff (!rstn) // RULE23
    $fell(outputEnableN) |-> (!outputEnableN && !chipSelectN) [*4])
    else $error("read strobe released too early");
  AST_ADDR_STEADY: assert property (@(posedge clock) disable iff (!rstn) // RULE2
    !outputEnableN && !$rose(outputEnableN) |=> $stable(flashAddr) || $rose(outputEnableN))
    else $error("address moved during read");
endmodule
`default_nettype wire

// >>> flash_status_poller.sv
// Notes on behaviour
// RULE1: program polling returns inverted bit seven until done
// RULE2: poll reads use the programmed address
// RULE3: protected program target polls busy about 1 us
// RULE4: erase polling bit reads 0, then 1
// RULE5: erase poll reads address inside erased sector
// RULE6: all-protected erase shows busy about 100 us
// RULE7: partly protected erase skips protected sectors
// RULE8: one more read after polling bit matches
// RULE9: first toggle bit inverts each read while busy
// RULE10: first toggle bit valid from last write
// RULE11: erase suspend stops first toggle bit
// RULE12: protected program target toggles about 2 us
// RULE13: suspend-program toggles first bit until done
// RULE14: second toggle bit toggles in erase sectors
// RULE15: suspend-program address reads second bit as 1
// RULE16: suspended sector status: 1, steady, toggling, ready
// RULE17: polling bit valid from final write strobe
// RULE18: second toggle bit valid from last strobe
// RULE19: judge both toggle bits together for mode
// RULE20: time-limit flag 1 marks failed operation
// RULE21: erase-window flag low until erase begins
// RULE22: ready-busy low while programming or erasing
// RULE23: strobe release completes read, steps toggles
//
// Added by the designer: the register addresses and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module flash_status_poller
  import flash_poll_pkg::*;
#(
  parameter int AW = FLASH_ADDR_W
) (
  input  wire logic          clock,
  input  wire logic          rstn,
  input  wire logic [4:0]    awaddr,
  input  wire logic          awvalid,
  output logic               awready,
  input  wire logic [31:0]   wdata,
  input  wire logic [3:0]    wstrb,
  input  wire logic          wvalid,
  output logic               wready,
  output logic [1:0]         bresp,
  output logic               bvalid,
  input  wire logic          bready,
  input  wire logic [4:0]    araddr,
  input  wire logic          arvalid,
  output logic               arready,
  output logic [31:0]        rdata,
  output logic [1:0]         rresp,
  output logic               rvalid,
  input  wire logic          rready,
  output logic               chipSelectN,
  output logic               outputEnableN,
  output logic               writeEnableN,
  output logic [AW-1:0]      flashAddr,
  input  wire logic [7:0]    dataPin,
  input  wire logic          readyBusyNPin
);
  typedef enum logic [1:0] {P_IDLE = 2'b00, P_ISSUE = 2'b01, P_WAIT = 2'b10} poll_state_t;
  typedef struct packed {
    logic          awReady;
    logic          awHave;
    logic [4:0]    awAddr;
    logic          wReady;
    logic          wHave;
    logic [31:0]   wData;
    logic [3:0]    wStrb;
    logic          bValid;
    logic [1:0]    bResp;
    logic          arReady;
    logic          rValid;
    logic [31:0]   rData;
    logic [1:0]    rResp;
    logic [2:0]    ctrl;
    logic [31:0]   pollAddr;
    logic [7:0]    expByte;
    poll_state_t   st;
    logic          startRd;
    logic          havePrev;
    logic          late;
    logic          confirm;
    logic [7:0]    prev;
    logic [7:0]    last;
    logic          done;
    logic          fail;
    logic          tog2;
    logic          susp;
  } poll_t;
  poll_t q;
  poll_t d;
  logic [7:0] rdByte;
  logic       rdDone;
  logic       readyLevel;
  logic       expBit;
  logic       tog1;

  function automatic logic [2:0] regIndex(input logic [4:0] a);
    unique case (a)
      OFF_CTRL:   regIndex = 3'h1;
      OFF_ADDR:   regIndex = 3'h2;
      OFF_EXPECT: regIndex = 3'h3;
      OFF_STATUS: regIndex = 3'h4;
      default:    regIndex = 3'h0;
    endcase
  endfunction

  function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
    mergeBytes = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        mergeBytes[8*i +: 8] = nw[8*i +: 8];
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  flash_read_cycle #(.AW(AW)) u_flash_read_cycle (
    .clock         (clock),
    .rstn          (rstn),
    .start         (q.startRd),
    .addrIn        (q.pollAddr[AW-1:0]),
    .dataPin       (dataPin),
    .readyBusyNPin (readyBusyNPin),
    .chipSelectN   (chipSelectN),
    .outputEnableN (outputEnableN),
    .flashAddr     (flashAddr),
    .byteOut       (rdByte),
    .readDone      (rdDone),
    .readyLevel    (readyLevel)
  );

  // erase completion always reads as 1; program as the written bit
  assign expBit = q.ctrl[CTRL_ERASE] ? 1'b1 : q.expByte[BIT_POLL]; // RULE1 RULE4
  assign tog1   = rdByte[BIT_TOG1] ^ q.prev[BIT_TOG1];

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [31:0] merged;
    merged    = mergeBytes(32'h0, q.wData, q.wStrb);
    d         = q;
    d.startRd = 1'b0;
    if (q.awReady && awvalid) begin
      d.awHave = 1'b1;
      d.awAddr = awaddr;
    end
    if (q.wReady && wvalid) begin
      d.wHave = 1'b1;
      d.wData = wdata;
      d.wStrb = wstrb;
    end
    if (q.bValid && bready) begin
      d.bValid = 1'b0;
    end
    if (q.awHave && q.wHave && !q.bValid) begin
      d.awHave = 1'b0;
      d.wHave  = 1'b0;
      d.bValid = 1'b1;
      d.bResp  = RESP_OKAY;
      unique case (regIndex(q.awAddr))
        3'h1: begin
          if (q.wStrb[0]) begin
            d.ctrl = merged[2:0];
          end
          // start only when idle; a start while busy is dropped
          if (q.wStrb[0] && merged[CTRL_START] && q.st == P_IDLE) begin
            d.st       = P_ISSUE;
            d.done     = 1'b0;
            d.fail     = 1'b0;
            d.tog2     = 1'b0;
            d.susp     = 1'b0;
            d.havePrev = 1'b0;
            d.late     = 1'b0;
            d.confirm  = 1'b0;
          end
        end
        3'h2:    d.pollAddr = mergeBytes(q.pollAddr, q.wData, q.wStrb); // RULE2 RULE5
        3'h3:    d.expByte = q.wStrb[0] ? q.wData[7:0] : q.expByte;
        3'h4:    d.bResp = RESP_OKAY;
        default: d.bResp = RESP_SLVERR;
      endcase
    end
    if (q.rValid && rready) begin
      d.rValid = 1'b0;
    end
    if (q.arReady && arvalid) begin
      d.rValid = 1'b1;
      d.rResp  = RESP_OKAY;
      unique case (regIndex(araddr))
        3'h1:    d.rData = {29'h0, q.ctrl & 3'h6};
        3'h2:    d.rData = q.pollAddr;
        3'h3:    d.rData = {24'h0, q.expByte};
        3'h4:    d.rData = {16'h0, q.last, readyLevel, q.susp, q.tog2, // RULE22
                            q.last[BIT_LIMIT], q.last[BIT_WINDOW], // RULE20 RULE21
                            q.fail, q.done, q.st != P_IDLE};
        default: begin
          d.rData = 32'h0;
          d.rResp = RESP_SLVERR;
        end
      endcase
    end
    unique case (q.st)
      // leave d.st alone: the write path above may have just started a poll
      P_IDLE: d.startRd = 1'b0;
      P_ISSUE: begin
        d.startRd = 1'b1;
        d.st      = P_WAIT;
      end
      P_WAIT: begin
        if (rdDone) begin
          d.last = rdByte;
          d.st   = P_ISSUE;
          if (q.confirm) begin
            // the extra read gives settled data on all eight bits
            d.done = 1'b1; // RULE8
            d.st   = P_IDLE;
          end else if (!q.ctrl[CTRL_TOGGLE]) begin
            if (rdByte[BIT_POLL] == expBit) begin
              d.confirm = 1'b1; // RULE8
            end else if (q.late) begin
              d.fail = 1'b1; // RULE20
              d.done = 1'b1;
              d.st   = P_IDLE;
            end else begin
              d.late = rdByte[BIT_LIMIT]; // RULE20
            end
          end else if (!q.havePrev) begin
            d.havePrev = 1'b1;
            d.prev     = rdByte;
          end else begin
            // mode and sector are only known from both toggle bits together
            d.tog2 = rdByte[BIT_TOG2] ^ q.prev[BIT_TOG2]; // RULE19
            d.susp = !tog1 && d.tog2; // RULE16 RULE19
            d.prev = rdByte;
            if (!tog1) begin
              d.confirm = 1'b1; // RULE9
            end else if (q.late) begin
              d.fail = 1'b1;
              d.done = 1'b1;
              d.st   = P_IDLE;
            end else begin
              d.late = rdByte[BIT_LIMIT]; // RULE20
            end
          end
        end
      end
      default: d.st = P_IDLE;
    endcase
    d.awReady = !d.awHave && !d.bValid;
    d.wReady  = !d.wHave && !d.bValid;
    d.arReady = !d.rValid;
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      q <= '{awReady: 1'b0, awHave: 1'b0, awAddr: 5'h00, wReady: 1'b0, wHave: 1'b0,
             wData: 32'h0, wStrb: 4'h0, bValid: 1'b0, bResp: RESP_OKAY, arReady: 1'b0,
             rValid: 1'b0, rData: 32'h0, rResp: RESP_OKAY, ctrl: CTRL_RESET,
             pollAddr: 32'h0, expByte: EXPECT_RESET, st: P_IDLE, startRd: 1'b0,
             havePrev: 1'b0, late: 1'b0, confirm: 1'b0, prev: 8'h00, last: 8'h00,
             done: 1'b0, fail: 1'b0, tog2: 1'b0, susp: 1'b0};
      writeEnableN <= 1'b1;
    end else begin
      q <= d;
      writeEnableN <= 1'b1;
    end
  end

  assign awready = q.awReady;
  assign wready  = q.wReady;
  assign bvalid  = q.bValid;
  assign bresp   = q.bResp;
  assign arready = q.arReady;
  assign rvalid  = q.rValid;
  assign rdata   = q.rData;
  assign rresp   = q.rResp;

  ////////////////////////////////////////////////////////////////////////////
  AST_POLL_ADDR: assert property (@(posedge clock) disable iff (!rstn) // RULE2
    $fell(outputEnableN) |-> flashAddr == q.pollAddr[AW-1:0])
    else $error("poll read not at programmed address");
  AST_CONFIRM_READ: assert property (@(posedge clock) disable iff (!rstn) // RULE8
    $rose(q.done) && !q.fail |-> $past(q.confirm) && $past(rdDone))
    else $error("success reported without confirming read");
  AST_PAIR_JUDGED: assert property (@(posedge clock) disable iff (!rstn) // RULE19
    $rose(q.susp) |-> q.ctrl[CTRL_TOGGLE] && $past(q.havePrev))
    else $error("suspend judged from a single read");
  AST_ERASE_POLL: assert property (@(posedge clock) disable iff (!rstn) // RULE4
    $rose(q.confirm) && q.ctrl[CTRL_ERASE] && !q.ctrl[CTRL_TOGGLE] |-> q.last[BIT_POLL])
    else $error("erase poll confirmed without polling bit set");
  AST_FAIL_LATE: assert property (@(posedge clock) disable iff (!rstn) // RULE20
    $rose(q.fail) |-> $past(q.late) && $past(rdDone))
    else $error("failure without time-limit recheck");
  AST_ISSUE_READ: assert property (@(posedge clock) disable iff (!rstn) // RULE2
    q.st == P_ISSUE |-> ##2 !outputEnableN)
    else $error("poll step did not start a read");
  AST_BHOLD: assert property (@(posedge clock) disable iff (!rstn)
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  AST_RHOLD: assert property (@(posedge clock) disable iff (!rstn)
    rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
endmodule
`default_nettype wire

// >>> flash_model.sv
`timescale 1ns/100ps
`default_nettype none
module flash_model (
  input  wire logic        chipSelectN,
  input  wire logic        outputEnableN,
  input  wire logic        writeEnableN,
  input  wire logic [21:0] flashAddr,
  input  wire logic        load,
  input  wire logic [1:0]  opKind,
  input  wire logic [7:0]  progByte,
  input  wire logic [7:0]  busyReads,
  input  wire logic        limitHit,
  input  wire logic        protect,
  output logic [7:0]       dataPin,
  output logic             readyBusyNPin,
  output logic [7:0]       readCount
);
  // opKind: 0 program, 1 erase, 2 erase suspended, 3 program in erase suspend; one sector
  logic       rdOff;
  logic       busy;
  logic [7:0] left     = 8'h00;
  logic       tog1     = 1'b0;
  logic       tog2     = 1'b0;
  logic [7:0] stat;
  logic [7:0] arrayByte;
  logic [7:0] lastByte = 8'h00;
  assign rdOff = chipSelectN | outputEnableN;
  assign busy = (left != 8'h00) && (opKind != 2'h2);
  assign readyBusyNPin = ~busy;
  ////////////////////////////////////////////////////////////////
  // status valid straight after load, no settling window
  // a protected target keeps its old contents: nothing programmed, nothing erased
  assign arrayByte = (opKind == 2'h1) ? 8'h00 : ~progByte;
  // the modelled sector stands for the unprotected part of a partly protected erase
  always_comb begin
    if (opKind == 2'h2) stat = {1'b1, tog1, 3'h0, tog2, 2'h0};
    else if (!busy && protect) stat = arrayByte;
    else if (!busy) stat = (opKind == 2'h1) ? 8'hff : progByte;
    else if (opKind == 2'h3)
      stat = {~progByte[7], tog1, limitHit, 2'h0, 1'b1, progByte[1:0]};
    else if (opKind == 2'h0)
      stat = {~progByte[7], tog1, limitHit, 3'h0, progByte[1:0]};
    else stat = {1'b0, tog1, limitHit, 1'b0, 1'b1, tog2, 2'h0};
  end
  // released bus shows the inverse of the last byte, never a helpful stale value
  assign dataPin = rdOff ? ~lastByte : stat;
  ////////////////////////////////////////////////////////////////
  always @(posedge rdOff or posedge load) begin
    if (load) begin
      left <= busyReads;
      tog1 <= 1'b0;
      tog2 <= 1'b0;
      readCount <= 8'h00;
    end else begin
      lastByte <= stat;
      readCount <= readCount + 8'h01;
      if (busy) tog1 <= ~tog1;
      if (opKind != 2'h0) tog2 <= ~tog2;
      // a time-limit failure locks the algorithm, it never finishes
      if (busy && !limitHit) left <= left - 8'h01;
    end
  end
endmodule
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import flash_poll_pkg::*;
  typedef struct {logic [31:0] data; logic [31:0] mask; logic [1:0] resp;} note_t;
  logic clock = 1'b0, rstn = 1'b0;
  logic [4:0] awaddr = 5'h00, araddr = 5'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, csN, oeN, weN, rbN;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [21:0] fAddr;
  logic [7:0] dPin, readCount, progByte = 8'h00, busyReads = 8'h00;
  logic load = 1'b0, limitHit = 1'b0, protect = 1'b0;
  logic [1:0] opKind = 2'h0;
  note_t expQ[$];
  note_t n;
  int fail_count = 0, comparisons = 0;
  logic [7:0] pb;
  always #5 clock = ~clock;
  flash_status_poller u_flash_status_poller (.clock(clock), .rstn(rstn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .chipSelectN(csN), .outputEnableN(oeN), .writeEnableN(weN),
    .flashAddr(fAddr), .dataPin(dPin), .readyBusyNPin(rbN));
  flash_model u_flash_model (.chipSelectN(csN), .outputEnableN(oeN), .writeEnableN(weN),
    .flashAddr(fAddr), .load(load), .opKind(opKind), .progByte(progByte),
    .busyReads(busyReads), .limitHit(limitHit), .protect(protect), .dataPin(dPin),
    .readyBusyNPin(rbN), .readCount(readCount));
  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [33:0] got, input logic [33:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("errors=%0d comparisons=%0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // answers are judged here so drivers never race the outputs
  always @(posedge clock) begin
    if ((rvalid === 1'b1 && rready) || (bvalid === 1'b1 && bready)) begin
      n = expQ.pop_front();
      if (rvalid) check({rresp, rdata & n.mask}, {n.resp, n.data & n.mask});
      else check({bresp, 32'h0}, {n.resp, 32'h0});
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic axi_write(input logic [4:0] a, input logic [31:0] d, input logic [3:0] s,
                           input logic [1:0] r);
    logic aw, w;
    expQ.push_back('{32'h0, 32'h0, r});
    awaddr <= a; awvalid <= 1'b1; wdata <= d; wstrb <= s; wvalid <= 1'b1; bready <= 1'b1;
    aw = 1'b0; w = 1'b0;
    while (!(aw && w)) begin
      @(posedge clock);
      if (!aw && awready) begin aw = 1'b1; awvalid <= 1'b0; end
      if (!w && wready) begin w = 1'b1; wvalid <= 1'b0; end
    end
    do @(posedge clock); while (bvalid !== 1'b1);
    bready <= 1'b0;
    @(posedge clock);
  endtask
  task automatic axi_read(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m,
                          input logic [1:0] r, output logic [31:0] d);
    expQ.push_back('{e, m, r});
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(posedge clock); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clock); while (rvalid !== 1'b1);
    d = rdata;
    rready <= 1'b0;
    @(posedge clock);
  endtask
  // er of 0 skips the read-count check where the count is the poller's own choice
  task automatic run_poll(input logic [2:0] ctl, input logic [1:0] op, input logic [7:0] b,
    input logic [7:0] br, input logic lim, input logic [31:0] es, input logic [31:0] em,
    input logic [7:0] er);
    logic [31:0] d;
    opKind <= op; progByte <= b; busyReads <= br; limitHit <= lim; load <= 1'b1;
    @(posedge clock);
    load <= 1'b0;
    axi_write(OFF_ADDR, 32'h00012345, 4'hf, RESP_OKAY);
    axi_write(OFF_EXPECT, {24'h0, b}, 4'h1, RESP_OKAY);
    axi_write(OFF_CTRL, {29'h0, ctl | 3'h1}, 4'h1, RESP_OKAY);
    // a second start while busy must be ignored yet answered OKAY
    axi_write(OFF_CTRL, {29'h0, ctl | 3'h1}, 4'h1, RESP_OKAY);
    d = 32'h0;
    while (d[1] !== 1'b1) axi_read(OFF_STATUS, 32'h0, 32'h0, RESP_OKAY, d);
    axi_read(OFF_STATUS, es, em, RESP_OKAY, d);
    if (er != 8'h00) check({26'h0, readCount}, {26'h0, er});
    check({12'h0, fAddr}, {12'h0, 22'h012345});
    check({33'h0, weN}, {33'h0, 1'b1});
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d;
    logic [7:0] br;
    void'($urandom(40));
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    axi_read(OFF_CTRL, {29'h0, CTRL_RESET}, 32'h7, RESP_OKAY, d);
    axi_read(OFF_EXPECT, {24'h0, EXPECT_RESET}, 32'hff, RESP_OKAY, d);
    axi_read(5'h10, 32'h0, 32'hffffffff, RESP_SLVERR, d);
    axi_write(5'h14, 32'h1, 4'hf, RESP_SLVERR);
    axi_write(OFF_EXPECT, 32'ha5, 4'h1, RESP_OKAY);
    axi_write(OFF_EXPECT, 32'h5a, 4'h0, RESP_OKAY);
    axi_read(OFF_EXPECT, 32'ha5, 32'hff, RESP_OKAY, d);
    pb = 8'($urandom);
    br = 8'($urandom_range(1, 6));
    run_poll(3'h0, 2'h0, pb, br, 1'b0, {16'h0, pb, 8'h82}, 32'hff87, br + 8'h2);
    br = 8'($urandom_range(1, 6));
    run_poll(3'h4, 2'h1, pb, br, 1'b0, 32'hff82, 32'hff87, br + 8'h2);
    run_poll(3'h0, 2'h0, pb, 8'h1, 1'b1, {16'h0, ~pb[7], 15'h2016}, 32'ha097, 8'h2);
    run_poll(3'h6, 2'h1, pb, 8'h1, 1'b1, 32'h281e, 32'ha89f, 8'h0);
    pb = 8'($urandom);
    run_poll(3'h2, 2'h0, pb, 8'h5, 1'b0, {16'h0, pb, 8'h82}, 32'hff87, 8'h0);
    run_poll(3'h6, 2'h2, pb, 8'h3, 1'b0, 32'h80e2, 32'hf8ff, 8'h0);
    run_poll(3'h4, 2'h2, pb, 8'h3, 1'b0, 32'h8082, 32'hf887, 8'h2);
    // protected targets are polled by toggling: the polling bit never reaches new data
    protect <= 1'b1;
    run_poll(3'h2, 2'h0, pb, 8'h2, 1'b0, {16'h0, ~pb, 8'h82}, 32'hff87, 8'h0);
    run_poll(3'h6, 2'h1, pb, 8'h2, 1'b0, 32'h0082, 32'hffe7, 8'h5);
    protect <= 1'b0;
    run_poll(3'h0, 2'h3, pb, 8'h1, 1'b1, {16'h0, ~pb[7], 15'h2416}, 32'hbc9f, 8'h2);
    run_poll(3'h2, 2'h3, pb, 8'h3, 1'b0, {16'h0, pb, 8'h82}, 32'hff87, 8'h0);
    axi_read(OFF_CTRL, 32'h0, 32'h1, RESP_OKAY, d);
    print_verdict();
  end
  initial begin
    repeat (30000) @(posedge clock);
    fail_count++;
    print_verdict();
  end
endmodule
`default_nettype wire
